// ==== core/front_panel_consts.svh ====
/*
 * Register offsets, field positions, reset values and timing counts for the
 * front panel status bank.
 * Assumes byte addressing on a 32-bit Avalon-MM bus, one word per register.
 */
// What this block does
// - valid integer file enables menus, 48 words
// - jog set: up/down change trimpot at once
// - jog clear: stage value, commit on confirm
// - jog changed by tool, software or menu
// - two trimpot words held within limits
// - download clamps out-of-range trimpot to bound
// - download modification raises error flag, number
// - error number 0 none, 1 corrupt, 2 range
// - window flag set in user message mode
// - confirm press latches flag until cleared
// - cancel press latches flag until cleared
// - key flags set only in message screen, cleared by software in any
// - timeout zero none, else exit after seconds
`ifndef FRONT_PANEL_CONSTS_SVH
`define FRONT_PANEL_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_FILE_SELECT   8'h00
`define OFS_CONTROL       8'h04
`define OFS_POT_ZERO      8'h08
`define OFS_POT_ONE       8'h0c
`define OFS_STATUS        8'h10
`define OFS_ERR_NUM       8'h14
`define OFS_LOWER_LIMIT   8'h18
`define OFS_UPPER_LIMIT   8'h1c
`define OFS_TIMEOUT       8'h20
`define OFS_IRQ_STATUS    8'h24
`define OFS_IRQ_MASK      8'h28

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_JOG           0
`define BIT_WINDOW        0
`define BIT_CONFIRM       1
`define BIT_CANCEL        2
`define BIT_DISP_ERR      3
`define IRQ_CONFIRM       0
`define IRQ_CANCEL        1
`define IRQ_MODIFIED      2

// ****************************************************************
// values
// ****************************************************************
`define JOG_RESET         1'b0
`define ERRNUM_NONE       16'h0000
`define ERRNUM_CORRUPT    16'h0001
`define ERRNUM_RANGE      16'h0002
`define INT_FILE_MIN      16'h0007
`define INT_FILE_MAX      16'h00ff
`define MONITOR_WORDS     6'h30
`define UNMAPPED_READ     32'h0000_0000

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS     8
`define ONE_SECOND_NS     1000000000
`define SECOND_CYCLES     (`ONE_SECOND_NS / `CLK_PERIOD_NS)

`endif

// ==== core/front_panel_pkg.sv ====
/*
 * Types shared by the front panel status bank.
 * Assumes the constants header is included by the design file.
 */
package front_panel_pkg;
  // display menu modes
  typedef enum logic [0:0] {
    MODE_SYSTEM,
    MODE_USER_MSG
  } menu_mode_type;
endpackage

// ==== core/lcd_keypad_trimpot_status.sv ====
/*
 * Front panel status and control bank: key flags, trimpot words, jog mode,
 * user message window and download range checks, on an Avalon-MM slave.
 * Assumes panel pins are asynchronous; tool configuration words are
 * quasi-static and come from the core clock domain.
 */
`timescale 1ns/1ps
`include "front_panel_consts.svh"

module lcd_keypad_trimpot_status #(
  parameter int unsigned SECOND_CYCLES = `SECOND_CYCLES
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  output logic             irq_o,
  input  wire logic        key_up_i,
  input  wire logic        key_down_i,
  input  wire logic        key_confirm_i,
  input  wire logic        key_cancel_i,
  input  wire logic        pot_select_i,
  input  wire logic        menu_enter_msg_i,
  input  wire logic        menu_jog_write_i,
  input  wire logic        menu_jog_value_i,
  input  wire logic        tool_jog_write_i,
  input  wire logic        tool_jog_value_i,
  input  wire logic        download_i,
  input  wire logic        retained_corrupt_i,
  input  wire logic [15:0] tool_file_select_i,
  input  wire logic [15:0] tool_lower_limit_i,
  input  wire logic [15:0] tool_upper_limit_i,
  input  wire logic [15:0] tool_timeout_i,
  input  wire logic [5:0]  monitor_index_i,
  output logic             monitor_menus_o,
  output logic             monitor_edit_ok_o,
  output logic             msg_indicator_o
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam int NPIN = 11;
  logic [NPIN-1:0] pin_meta_reg;
  logic [NPIN-1:0] pin_sync_reg;
  logic [NPIN-1:0] pin_last_reg;
  logic [NPIN-1:0] pin_rise;

  // two stages before any logic looks at a pin; all stages clear in reset
  // so an unknown pin level cannot fake a press just after release
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_last_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= {retained_corrupt_i, tool_jog_value_i, menu_jog_value_i,
                       pot_select_i, tool_jog_write_i, menu_jog_write_i,
                       menu_enter_msg_i, download_i, key_cancel_i,
                       key_confirm_i, key_up_i};
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
    end
  end

  assign pin_rise = pin_sync_reg & ~pin_last_reg;

  logic down_meta_reg;
  logic down_sync_reg;
  logic down_last_reg;

  always_ff @(posedge core_clk_i)
  begin
    down_meta_reg <= rst_i ? 1'b0 : key_down_i;
    down_sync_reg <= rst_i ? 1'b0 : down_meta_reg;
    down_last_reg <= rst_i ? 1'b0 : down_sync_reg;
  end

  logic up_press;
  logic down_press;
  logic confirm_press;
  logic cancel_press;
  logic download_ev;
  logic enter_ev;
  logic menu_jog_ev;
  logic tool_jog_ev;
  logic pot_sel;
  logic menu_jog_val;
  logic tool_jog_val;
  logic corrupt_lvl;

  assign up_press      = pin_rise[0];
  assign confirm_press = pin_rise[1];
  assign cancel_press  = pin_rise[2];
  assign download_ev   = pin_rise[3];
  assign enter_ev      = pin_rise[4];
  assign menu_jog_ev   = pin_rise[5];
  assign tool_jog_ev   = pin_rise[6];
  assign pot_sel       = pin_sync_reg[7];
  assign menu_jog_val  = pin_sync_reg[8];
  assign tool_jog_val  = pin_sync_reg[9];
  assign corrupt_lvl   = pin_sync_reg[10];
  assign down_press    = down_sync_reg & ~down_last_reg;

  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic ack_reg;
  logic rd_take;
  logic wr_take;

  // one wait cycle per access, then the answer
  always_ff @(posedge core_clk_i)
  begin
    ack_reg <= rst_i ? 1'b0 : ((read_i | write_i) & ~ack_reg);
  end

  assign waitrequest_o = (read_i | write_i) & ~ack_reg;
  assign rd_take       = read_i & ack_reg;
  assign wr_take       = write_i & ack_reg;

  // ****************************************************************
  // menu mode and input timeout
  // ****************************************************************
  front_panel_pkg::menu_mode_type mode_reg;
  logic [31:0] tick_reg;
  logic [15:0] idle_sec_reg;
  logic        any_key;
  logic        timeout_hit;

  assign any_key     = up_press | down_press | confirm_press | cancel_press;
  assign timeout_hit = (tool_timeout_i != 16'h0000) &&
                       (idle_sec_reg >= tool_timeout_i);

  // idle seconds restart on every key
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || any_key || mode_reg != front_panel_pkg::MODE_USER_MSG)
    begin
      tick_reg     <= 32'h0;
      idle_sec_reg <= 16'h0;
    end
    else if (tick_reg == 32'(SECOND_CYCLES - 1))
    begin
      tick_reg     <= 32'h0;
      idle_sec_reg <= idle_sec_reg + 16'h1;
    end
    else
      tick_reg <= tick_reg + 32'h1;
  end

  // display enters message mode, timeout returns to upper menu
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      mode_reg <= front_panel_pkg::MODE_SYSTEM;
    else
    begin
      unique case (mode_reg)
        front_panel_pkg::MODE_SYSTEM:
          if (enter_ev)
            mode_reg <= front_panel_pkg::MODE_USER_MSG;
        front_panel_pkg::MODE_USER_MSG:
          if (timeout_hit)
            mode_reg <= front_panel_pkg::MODE_SYSTEM;
      endcase
    end
  end

  logic in_msg;
  assign in_msg          = (mode_reg == front_panel_pkg::MODE_USER_MSG);
  assign msg_indicator_o = in_msg;

  // ****************************************************************
  // jog mode
  // ****************************************************************
  logic jog_reg;

  // tool beats menu beats software when they collide
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      jog_reg <= `JOG_RESET;
    else if (tool_jog_ev)
      jog_reg <= tool_jog_val;
    else if (menu_jog_ev)
      jog_reg <= menu_jog_val;
    else if (wr_take && address_i == `OFS_CONTROL)
      jog_reg <= writedata_i[`BIT_JOG];
  end

  // ****************************************************************
  // trimpots
  // ****************************************************************
  logic signed [15:0] pot_reg [2];
  logic signed [15:0] stage_reg;
  logic               staging_reg;
  logic signed [15:0] lo;
  logic signed [15:0] hi;
  logic signed [15:0] cur;
  logic signed [15:0] base;
  logic signed [15:0] bumped;

  assign lo     = $signed(tool_lower_limit_i);
  assign hi     = $signed(tool_upper_limit_i);
  assign cur    = pot_reg[pot_sel];
  assign base   = staging_reg ? stage_reg : cur;
  // step clamps at the range ends so the word never leaves the limits
  assign bumped = (up_press && base < hi) ? base + 16'sd1 :
                  (down_press && base > lo) ? base - 16'sd1 : base;

  logic [1:0] modified;
  logic [1:0] corrupt_any;

  // download clamps each retained value to the new range
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pot_reg[0] <= 16'sh0;
      pot_reg[1] <= 16'sh0;
    end
    else if (download_ev)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (corrupt_lvl)
          pot_reg[i] <= lo;
        else if (pot_reg[i] > hi)
          pot_reg[i] <= hi;
        else if (pot_reg[i] < lo)
          pot_reg[i] <= lo;
      end
    end
    else if (jog_reg && !in_msg && (up_press || down_press))
      pot_reg[pot_sel] <= bumped;
    else if (!jog_reg && staging_reg && confirm_press && !in_msg)
      pot_reg[pot_sel] <= stage_reg;
  end

  // pending edit held only while jog is clear
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || download_ev || jog_reg || in_msg)
    begin
      staging_reg <= 1'b0;
      stage_reg   <= 16'sh0;
    end
    else if (up_press || down_press)
    begin
      staging_reg <= 1'b1;
      stage_reg   <= bumped;
    end
    else if (confirm_press || cancel_press)
      staging_reg <= 1'b0;
  end

  // ****************************************************************
  // download error report
  // ****************************************************************
  logic        disp_err_reg;
  logic [15:0] err_num_reg;

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      modified[i]    = (pot_reg[i] > hi) || (pot_reg[i] < lo);
      corrupt_any[i] = corrupt_lvl;
    end
  end

  // flag set on a modifying download and cleared on a clean one
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      disp_err_reg <= 1'b0;
      err_num_reg  <= `ERRNUM_NONE;
    end
    else if (download_ev)
    begin
      disp_err_reg <= corrupt_any[0] | (|modified);
      err_num_reg  <= corrupt_any[0] ? `ERRNUM_CORRUPT :
                      (|modified)    ? `ERRNUM_RANGE : `ERRNUM_NONE;
    end
  end

  // ****************************************************************
  // key flags
  // ****************************************************************
  logic confirm_reg;
  logic cancel_reg;
  logic st_wr;

  assign st_wr = wr_take && address_i == `OFS_STATUS;

  // a press in the clearing cycle wins; other screens leave flags alone
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      confirm_reg <= 1'b0;
      cancel_reg  <= 1'b0;
    end
    else
    begin
      if (in_msg && confirm_press)
        confirm_reg <= 1'b1;
      else if (st_wr && !writedata_i[`BIT_CONFIRM])
        confirm_reg <= 1'b0;
      if (in_msg && cancel_press)
        cancel_reg <= 1'b1;
      else if (st_wr && !writedata_i[`BIT_CANCEL])
        cancel_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic [2:0] irq_st_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_ev;
  logic       irq_rd;

  assign irq_ev = {download_ev & (corrupt_any[0] | (|modified)),
                   in_msg & cancel_press, in_msg & confirm_press};
  assign irq_rd = rd_take && address_i == `OFS_IRQ_STATUS;

  // read clears, but a new event in that cycle survives
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      irq_st_reg <= 3'h0;
    else
      irq_st_reg <= (irq_rd ? 3'h0 : irq_st_reg) | irq_ev;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      irq_mask_reg <= 3'h0;
    else if (wr_take && address_i == `OFS_IRQ_MASK)
      irq_mask_reg <= writedata_i[2:0];
  end

  assign irq_o = |(irq_st_reg & irq_mask_reg);

  // ****************************************************************
  // integer monitor menus
  // ****************************************************************
  logic file_ok;
  assign file_ok = tool_file_select_i >= `INT_FILE_MIN &&
                   tool_file_select_i <= `INT_FILE_MAX;
  assign monitor_menus_o   = file_ok;
  assign monitor_edit_ok_o = file_ok && (monitor_index_i < `MONITOR_WORDS);

  // ****************************************************************
  // read data
  // ****************************************************************
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      readdata_o <= 32'h0;
    else if ((read_i | write_i) & ~ack_reg & read_i)
    begin
      unique case (address_i)
        `OFS_FILE_SELECT: readdata_o <= {16'h0, tool_file_select_i};
        `OFS_CONTROL:     readdata_o <= {31'h0, jog_reg};
        `OFS_POT_ZERO:    readdata_o <= {16'h0, pot_reg[0]};
        `OFS_POT_ONE:     readdata_o <= {16'h0, pot_reg[1]};
        `OFS_STATUS:      readdata_o <= {28'h0, disp_err_reg, cancel_reg,
                                         confirm_reg, in_msg};
        `OFS_ERR_NUM:     readdata_o <= {16'h0, err_num_reg};
        `OFS_LOWER_LIMIT: readdata_o <= {16'h0, tool_lower_limit_i};
        `OFS_UPPER_LIMIT: readdata_o <= {16'h0, tool_upper_limit_i};
        `OFS_TIMEOUT:     readdata_o <= {16'h0, tool_timeout_i};
        `OFS_IRQ_STATUS:  readdata_o <= {29'h0, irq_st_reg};
        `OFS_IRQ_MASK:    readdata_o <= {29'h0, irq_mask_reg};
        default:          readdata_o <= `UNMAPPED_READ;
      endcase
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence confirm_in_msg_s;
    in_msg && confirm_press;
  endsequence

  sequence zero_clear_s;
    st_wr && !writedata_i[`BIT_CONFIRM] && !(in_msg && confirm_press);
  endsequence

  a_confirm_latch: assert property (@(posedge core_clk_i) disable iff (rst_i)
    confirm_in_msg_s |=> confirm_reg)
    else $error("confirm press not latched");

  a_cancel_latch: assert property (@(posedge core_clk_i) disable iff (rst_i)
    in_msg && cancel_press |=> cancel_reg)
    else $error("cancel press not latched");

  a_flag_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    confirm_reg && !st_wr |=> confirm_reg)
    else $error("confirm flag dropped without clear");

  a_screen_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !in_msg && !st_wr |=> $stable(confirm_reg) && $stable(cancel_reg))
    else $error("key flag changed outside message screen");

  a_zero_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    zero_clear_s |=> !confirm_reg)
    else $error("zero write did not clear confirm");

  a_pot_range: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $past(download_ev) && !$past(corrupt_lvl) && $stable(tool_lower_limit_i)
    && $stable(tool_upper_limit_i) |-> pot_reg[0] >= lo && pot_reg[0] <= hi)
    else $error("trimpot not clamped at download");

  a_err_code: assert property (@(posedge core_clk_i) disable iff (rst_i)
    download_ev && !corrupt_lvl && (|modified) |=>
    disp_err_reg && err_num_reg == `ERRNUM_RANGE)
    else $error("range error not reported");

  a_jog_direct: assert property (@(posedge core_clk_i) disable iff (rst_i)
    jog_reg && !in_msg && !download_ev && up_press && cur < hi
    |=> pot_reg[$past(pot_sel)] == $past(cur) + 16'sd1)
    else $error("jog step not applied at once");

  a_stage_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !jog_reg && !download_ev && !confirm_press |=> $stable(pot_reg[0]))
    else $error("trimpot changed without confirm");

  a_timeout_none: assert property (@(posedge core_clk_i) disable iff (rst_i)
    in_msg && tool_timeout_i == 16'h0000 |=> in_msg)
    else $error("left message mode with no timeout");

  a_bus_answer: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (read_i || write_i) && !ack_reg |=> !waitrequest_o)
    else $error("slave answer later than one wait cycle");

endmodule // lcd_keypad_trimpot_status

// ==== verif/front_panel_model.sv ====
/*
 * Behavioural keypad of the front panel: makes one key press on request.
 * Assumes a request only while busy_o is low; the pins idle low.
 */
`timescale 1ns/1ps

module front_panel_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [1:0] code_i,
  output logic            key_up_o,
  output logic            key_down_o,
  output logic            key_confirm_o,
  output logic            key_cancel_o,
  output logic            busy_o
);
  logic [3:0] step_reg;
  logic [1:0] code_reg;

  // pin high 5 cycles, then low long enough for the synchroniser to see
  // a clean release before the next press
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      step_reg <= 4'h0;
      code_reg <= 2'h0;
    end
    else if (step_reg != 4'h0)
      step_reg <= step_reg + 4'h1;
    else if (go_i)
    begin
      step_reg <= 4'h1;
      code_reg <= code_i;
    end
  end

  // one key at a time: 0 up, 1 down, 2 confirm, 3 cancel
  assign busy_o        = (step_reg != 4'h0);
  assign key_up_o      = busy_o && (step_reg < 4'h6) && (code_reg == 2'h0);
  assign key_down_o    = busy_o && (step_reg < 4'h6) && (code_reg == 2'h1);
  assign key_confirm_o = busy_o && (step_reg < 4'h6) && (code_reg == 2'h2);
  assign key_cancel_o  = busy_o && (step_reg < 4'h6) && (code_reg == 2'h3);
endmodule // front_panel_model

// ==== verif/lcd_keypad_trimpot_status_tb.sv ====
/*
 * Self-checking bench of the front panel status bank.
 * Assumes the constants header on the include path and the panel model.
 */
`timescale 1ns/1ps
`include "front_panel_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end

module lcd_keypad_trimpot_status_tb;
  // short second keeps the idle exit test brief
  localparam int unsigned SEC = 10;
  logic        clk, rst, rd, wr, waitreq, wait_s, irq, go, busy;
  logic        up, down, conf, canc, psel, menu_msg, menu_jw, menu_jv;
  logic        tool_jw, tool_jv, dl, corrupt, menus, edit_allowed, indicator;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rd_s, rdv, seed;
  logic [15:0] fsel, lo, hi, tmo, lv, hv, exp0, exp1, err_e;
  logic [5:0]  midx;
  logic [1:0]  code;
  int          n_errors, compares;

  lcd_keypad_trimpot_status #(.SECOND_CYCLES(SEC)) dut (
    .core_clk_i(clk), .rst_i(rst), .address_i(addr), .read_i(rd), .write_i(wr),
    .writedata_i(wdata), .readdata_o(rdata), .waitrequest_o(waitreq), .irq_o(irq),
    .key_up_i(up), .key_down_i(down), .key_confirm_i(conf), .key_cancel_i(canc),
    .pot_select_i(psel), .menu_enter_msg_i(menu_msg), .menu_jog_write_i(menu_jw),
    .menu_jog_value_i(menu_jv), .tool_jog_write_i(tool_jw),
    .tool_jog_value_i(tool_jv), .download_i(dl), .retained_corrupt_i(corrupt),
    .tool_file_select_i(fsel), .tool_lower_limit_i(lo), .tool_upper_limit_i(hi),
    .tool_timeout_i(tmo), .monitor_index_i(midx), .monitor_menus_o(menus),
    .monitor_edit_ok_o(edit_allowed), .msg_indicator_o(indicator));

  front_panel_model panel (
    .clk_i(clk), .rst_i(rst), .go_i(go), .code_i(code), .key_up_o(up),
    .key_down_o(down), .key_confirm_o(conf), .key_cancel_o(canc), .busy_o(busy));

  always #4 clk = ~clk;

  // mid-cycle copies: what the next rising edge will sample
  always @(negedge clk)
  begin
    wait_s <= waitreq;
    rd_s   <= rdata;
  end

  function logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function logic [15:0] clamp(logic [15:0] v, logic [15:0] l, logic [15:0] h);
    if ($signed(v) < $signed(l))
      return l;
    if ($signed(v) > $signed(h))
      return h;
    return v;
  endfunction

  task wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one Avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= w;
      rd    <= !w;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (wait_s !== 1'b0 && n < 50);
      if (n >= 50)
        n_errors++;
      rdv = rd_s;
      rd  <= 1'b0;
      wr  <= 1'b0;
    end
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rdv, e)
  endtask

  task press(input logic [1:0] c);
    int n;
    begin
      n = 0;
      @(posedge clk);
      go   <= 1'b1;
      code <= c;
      @(posedge clk);
      go <= 1'b0;
      do
      begin
        @(negedge clk);
        n++;
      end
      while (busy !== 1'b0 && n < 50);
      wait_cyc(3);
    end
  endtask

  // level held long enough for the synchroniser and edge detector
  task download(input logic c);
    corrupt <= c;
    dl      <= 1'b1;
    wait_cyc(4);
    dl <= 1'b0;
    wait_cyc(6);
  endtask

  task give_verdict();
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog far beyond the expected run of about four hundred cycles
  initial
  begin
    wait_cyc(20000);
    n_errors++;
    give_verdict();
  end

  initial
  begin
    {clk, rd, wr, go, psel, menu_msg, menu_jw, menu_jv, tool_jw, tool_jv} = '0;
    {dl, corrupt} = '0;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    code = 2'h0;
    fsel = 16'h0008;
    lo = 16'h0000;
    hi = 16'h0000;
    tmo = 16'h0000;
    midx = 6'h00;
    seed = 32'h0000_2be0;
    n_errors = 0;
    compares = 0;
    wait_cyc(2);
    rst <= 1'b0;
    // reset state, unmapped and read-only places
    rd_chk(`OFS_STATUS, 32'h0);
    rd_chk(`OFS_CONTROL, 32'h0);
    rd_chk(`OFS_POT_ZERO, 32'h0);
    rd_chk(8'h2c, 32'h0);
    `CHK(irq, 1'b0)
    bus(1'b1, `OFS_FILE_SELECT, 32'hffff);
    rd_chk(`OFS_FILE_SELECT, 32'h0008);
    // file bounds and the 48-word edit window
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      fsel <= (i % 4 == 0) ? 16'h0006 : (i % 4 == 1) ? 16'h0007 :
              (i % 4 == 2) ? 16'h00ff : 16'h0100;
      midx <= (i == 1) ? 6'h2f : (i == 2) ? 6'h30 : 6'(next_rand());
      @(negedge clk);
      `CHK(menus, (fsel >= 16'h0007 && fsel <= 16'h00ff))
      `CHK(edit_allowed, (fsel >= `INT_FILE_MIN && fsel <= `INT_FILE_MAX) && midx < 6'h30)
    end
    // downloads with random ranges, first one forced out of range
    exp0 = 16'h0;
    exp1 = 16'h0;
    for (int i = 0; i < 5; i++)
    begin
      lv = (i == 0) ? 16'h000a : 16'(next_rand() % 32'd40);
      hv = (i == 0) ? 16'h0014 : lv + 16'(next_rand() % 32'd40);
      err_e = (clamp(exp0, lv, hv) != exp0 || clamp(exp1, lv, hv) != exp1) ?
              `ERRNUM_RANGE : `ERRNUM_NONE;
      exp0 = clamp(exp0, lv, hv);
      exp1 = clamp(exp1, lv, hv);
      lo <= lv;
      hi <= hv;
      download(1'b0);
      rd_chk(`OFS_POT_ZERO, {16'h0, exp0});
      rd_chk(`OFS_POT_ONE, {16'h0, exp1});
      rd_chk(`OFS_ERR_NUM, {16'h0, err_e});
      bus(1'b0, `OFS_STATUS, 32'h0);
      `CHK(rdv[3], err_e != 16'h0)
    end
    lo <= 16'h000a;
    hi <= 16'h0014;
    download(1'b1);
    rd_chk(`OFS_POT_ONE, 32'h000a);
    rd_chk(`OFS_ERR_NUM, 32'h1);
    // immediate edits, then a refused step below the lower limit
    bus(1'b1, `OFS_CONTROL, 32'h1);
    rd_chk(`OFS_CONTROL, 32'h1);
    press(2'h0);
    rd_chk(`OFS_POT_ZERO, 32'h000b);
    psel <= 1'b1;
    press(2'h1);
    rd_chk(`OFS_POT_ONE, 32'h000a);
    // staged edit committed only by confirm
    psel <= 1'b0;
    bus(1'b1, `OFS_CONTROL, 32'h0);
    press(2'h0);
    rd_chk(`OFS_POT_ZERO, 32'h000b);
    press(2'h2);
    rd_chk(`OFS_POT_ZERO, 32'h000c);
    bus(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rdv[2:1], 2'b00)
    // tool and menu sources of the update mode
    tool_jv <= 1'b1;
    tool_jw <= 1'b1;
    wait_cyc(4);
    tool_jw <= 1'b0;
    wait_cyc(4);
    rd_chk(`OFS_CONTROL, 32'h1);
    menu_jw <= 1'b1;
    wait_cyc(4);
    menu_jw <= 1'b0;
    wait_cyc(4);
    rd_chk(`OFS_CONTROL, 32'h0);
    // message screen: latched keys, interrupt, clears
    menu_msg <= 1'b1;
    wait_cyc(4);
    menu_msg <= 1'b0;
    wait_cyc(4);
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    press(2'h2);
    bus(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rdv[2:0], 3'b011)
    `CHK(indicator, 1'b1)
    `CHK(irq, 1'b1)
    bus(1'b0, `OFS_IRQ_STATUS, 32'h0);
    `CHK(rdv[0], 1'b1)
    rd_chk(`OFS_IRQ_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    press(2'h3);
    bus(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rdv[2:0], 3'b111)
    `CHK(irq, 1'b0)
    bus(1'b1, `OFS_STATUS, 32'h4);
    bus(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rdv[2:0], 3'b101)
    bus(1'b1, `OFS_STATUS, 32'h0);
    bus(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rdv[2:0], 3'b001)
    // a one-second limit ends the idle message screen
    tmo <= 16'h0001;
    wait_cyc(40);
    bus(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rdv[0], 1'b0)
    `CHK(indicator, 1'b0)
    give_verdict();
  end
endmodule // lcd_keypad_trimpot_status_tb
